/* hdl/plsr_top.sv */
// Composite status and clock-disable control of a 10/100 PHY, APB slave
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
// ------------------------------------------------------------------------
// Summary of operation
// - Bit 8 latches page-received, cleared by expansion read
// - Bit 7 pending interrupt, cleared by source read
// - Bit 6 remote fault, cleared by basic-status read
// - Bit 5 mirrors jabber at 10 Mbps only, not read-cleared
// - Bit 4 shows autonegotiation complete
// - Bit 3 shows loopback enabled
// - Bit 2 shows full duplex
// - Bit 0 mirrors link, not read-cleared
// - Control bit 15 disables internal clocks while in power-down
// ------------------------------------------------------------------------
module plsr_top (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Internal state from link, negotiation and interrupt logic (asynchronous)
  input  wire logic        page_rx_evt,
  input  wire logic        intr_pending,
  input  wire logic        rfault_evt,
  input  wire logic        jabber_det,
  input  wire logic        aneg_done,
  input  wire logic        loopback_en,
  input  wire logic        full_duplex,
  input  wire logic        speed_10,
  input  wire logic        link_up,
  input  wire logic        power_down,
  // Clock circuitry control
  output logic             clk_disable
);
  import plsr_pkg::*;

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  // Event inputs are level-synchronised; a short pulse must last one clock
  localparam int NIN = 10;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] sy1_q;
  logic [NIN-1:0] sy2_q;
  logic [NIN-1:0] sy2_d;
  assign raw_in = {power_down, link_up, speed_10, full_duplex, loopback_en,
                   aneg_done, jabber_det, rfault_evt, intr_pending, page_rx_evt};
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          sy1_q[gi] <= 1'b0;
          sy2_q[gi] <= 1'b0;
        end else begin
          sy1_q[gi] <= raw_in[gi];
          sy2_q[gi] <= sy2_d[gi];
        end
      end
      assign sy2_d[gi] = sy1_q[gi];
    end
  endgenerate

  logic s_page, s_intr, s_rflt, s_jab, s_aneg, s_lpbk, s_dup, s_spd, s_link, s_pdn;
  assign {s_pdn, s_link, s_spd, s_dup, s_lpbk, s_aneg, s_jab, s_rflt, s_intr, s_page} = sy2_q;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic       acc;
  logic       rd_acc;
  logic [7:0] idx;
  logic       mapped;
  logic       rd_exp, rd_src, rd_bsr;
  assign acc    = psel & penable & pready;
  assign rd_acc = acc & ~pwrite;
  assign idx    = paddr[9:2];
  // Misaligned addresses are refused rather than rounded down to a word
  assign mapped = (paddr[1:0] == 2'h0) &&
                  (idx == IDX_COMPOSITE_STAT || idx == IDX_SPECIFIC_CTRL ||
                   idx == IDX_BASIC_STATUS || idx == IDX_AUTONEG_EXP ||
                   idx == IDX_INTR_SOURCE);
  assign rd_exp = rd_acc && idx == IDX_AUTONEG_EXP && paddr[1:0] == 2'h0;
  assign rd_src = rd_acc && idx == IDX_INTR_SOURCE && paddr[1:0] == 2'h0;
  assign rd_bsr = rd_acc && idx == IDX_BASIC_STATUS && paddr[1:0] == 2'h0;

  // ----------------------------------------------------------------------
  // Sticky status and control state
  // ----------------------------------------------------------------------
  logic        page_q, page_d;
  logic        intr_q, intr_d;
  logic        rflt_q, rflt_d;
  logic        intr_prev_q, intr_prev_d;
  logic [15:0] ctrl_q, ctrl_d;
  logic        clk_dis_d;

  always_comb begin
    // Set beats clear so an event in the clearing cycle survives
    page_d      = s_page | (page_q & ~rd_exp);
    // Latch on a new pending edge; the source read acknowledges it
    intr_prev_d = s_intr;
    intr_d      = (s_intr & ~intr_prev_q) | (intr_q & ~rd_src);
    rflt_d      = s_rflt | (rflt_q & ~rd_bsr);
    ctrl_d      = ctrl_q;
    if (acc && pwrite && idx == IDX_SPECIFIC_CTRL && paddr[1:0] == 2'h0) begin
      ctrl_d = (ctrl_q & ~CTRL_WR_MASK) | (pwdata[15:0] & CTRL_WR_MASK);
    end
    // Clocks stop only while in power-down, protecting a stray write
    clk_dis_d   = ctrl_d[CTL_CLK_DIS] & s_pdn;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      page_q      <= 1'b0;
      intr_q      <= 1'b0;
      rflt_q      <= 1'b0;
      intr_prev_q <= 1'b0;
      ctrl_q      <= SPECIFIC_CTRL_RST;
      clk_disable <= 1'b0;
    end else begin
      page_q      <= page_d;
      intr_q      <= intr_d;
      rflt_q      <= rflt_d;
      intr_prev_q <= intr_prev_d;
      ctrl_q      <= ctrl_d;
      clk_disable <= clk_dis_d;
    end
  end

  // ----------------------------------------------------------------------
  // Composite status word
  // ----------------------------------------------------------------------
  logic [15:0] sts;
  always_comb begin
    sts = 16'h0000;
    sts[STS_PAGE_RX]   = page_q;
    sts[STS_INTR]      = intr_q | s_intr;
    sts[STS_RFAULT]    = rflt_q;
    sts[STS_JABBER]    = s_jab & s_spd;
    sts[STS_ANEG_DONE] = s_aneg;
    sts[STS_LOOPBACK]  = s_lpbk;
    sts[STS_DUPLEX]    = s_dup;
    sts[STS_SPEED10]   = s_spd;
    sts[STS_LINK]      = s_link;
  end

  // ----------------------------------------------------------------------
  // APB answer: no wait state; pready is a flip-flop loaded in the setup phase
  // ----------------------------------------------------------------------
  logic [31:0] prdata_d;
  logic        pready_d;
  logic        pslverr_d;
  always_comb begin
    pready_d  = psel & ~penable;
    prdata_d  = prdata;
    pslverr_d = 1'b0;
    if (psel && !penable) begin
      prdata_d  = 32'h0000_0000;
      pslverr_d = ~mapped;
      if (!pwrite && paddr[1:0] == 2'h0) begin
        case (idx)
          IDX_COMPOSITE_STAT: prdata_d = {16'h0000, sts};
          IDX_SPECIFIC_CTRL:  prdata_d = {16'h0000, ctrl_q};
          IDX_BASIC_STATUS:   prdata_d = {29'h0, s_link, s_jab & s_spd, 1'b0};
          IDX_AUTONEG_EXP:    prdata_d = {30'h0, page_q, 1'b0};
          IDX_INTR_SOURCE:    prdata_d = {31'h0, intr_q | s_intr};
          default:            prdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= prdata_d;
      pready  <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence exp_read_s;
    rd_exp && !s_page;
  endsequence

  // Pin mirrors lag two clocks; skip the edges whose history is still in reset
  sequence synced_s;
    $past(rst_n, 2);
  endsequence

  page_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    exp_read_s |=> !page_q) else $error("page flag not cleared by expansion read");
  page_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_page |=> page_q) else $error("page flag not set");
  intr_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (intr_q && !rd_src) |=> intr_q) else $error("interrupt flag lost");
  intr_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rd_src && !(s_intr && !intr_prev_q)) |=> !intr_q) else $error("interrupt flag not cleared");
  rflt_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rflt_q && !rd_bsr) |=> rflt_q) else $error("remote fault dropped early");
  rflt_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rd_bsr && !s_rflt) |=> !rflt_q) else $error("remote fault not cleared");
  jab_speed_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sts[STS_JABBER] |-> sts[STS_SPEED10]) else $error("jabber shown at 100 Mbps");
  link_mirror_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    synced_s |-> sts[STS_LINK] == $past(link_up, 2)) else $error("link bit not mirrored");
  sts_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (acc && pwrite && idx == IDX_COMPOSITE_STAT) |=> $stable(ctrl_q))
    else $error("status write changed control");
  clk_dis_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_disable |-> $past(s_pdn)) else $error("clocks disabled outside power-down");
  ready_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (psel && !penable) |=> pready) else $error("no answer after setup");

  // ----------------------------------------------------------------------
  // Status assertions
  // ----------------------------------------------------------------------
  // Latched flags must catch every synchronised event
  page_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (page_q && !rd_exp) |=> page_q) else $error("page flag dropped early");
  intr_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s_intr && !intr_prev_q) |=> intr_q) else $error("interrupt edge not latched");
  intr_live_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_intr |-> sts[STS_INTR]) else $error("pending interrupt not shown");
  rflt_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_rflt |=> rflt_q) else $error("remote fault not latched");

  // Level bits follow their pins two clocks late, checked against the pins
  jab_mirror_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    synced_s |-> sts[STS_JABBER] == ($past(jabber_det, 2) && $past(speed_10, 2)))
    else $error("jabber bit wrong");
  aneg_mirror_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    synced_s |-> sts[STS_ANEG_DONE] == $past(aneg_done, 2))
    else $error("autonegotiation bit wrong");
  lpbk_mirror_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    synced_s |-> sts[STS_LOOPBACK] == $past(loopback_en, 2))
    else $error("loopback bit wrong");
  dup_mirror_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    synced_s |-> sts[STS_DUPLEX] == $past(full_duplex, 2))
    else $error("duplex bit wrong");
  spd_mirror_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    synced_s |-> sts[STS_SPEED10] == $past(speed_10, 2))
    else $error("speed bit wrong");

  // Upper status bits belong to other logic and read as zero here
  sts_upper_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sts[15:9] == 7'h00)
    else $error("upper status bits not zero");

  // ----------------------------------------------------------------------
  // Bus and control assertions
  // ----------------------------------------------------------------------
  sequence setup_s;
    psel && !penable;
  endsequence

  sequence access_s;
    psel && penable && pready;
  endsequence

  // A control write is an access phase aimed at the aligned control word
  sequence ctrl_wr_s;
    access_s ##0 (pwrite && idx == IDX_SPECIFIC_CTRL && paddr[1:0] == 2'h0);
  endsequence

  // One answer per transfer, and an error only alongside it
  ready_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pready |=> !pready) else $error("ready held past one cycle");
  err_qual_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pslverr |-> pready) else $error("error flag without ready");
  unmapped_err_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (setup_s ##0 !mapped) |=> pslverr) else $error("unmapped access not flagged");
  mapped_ok_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (setup_s ##0 mapped) |=> !pslverr) else $error("mapped access flagged");
  data_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(psel && !penable) |=> $stable(prdata)) else $error("read data moved outside setup");

  // Only bit 15 of the control word may move, and only by a write
  ctrl_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctrl_wr_s |=> ctrl_q[CTL_CLK_DIS] == $past(pwdata[CTL_CLK_DIS]))
    else $error("clock-disable bit not written");
  ctrl_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctrl_q[14:0] == SPECIFIC_CTRL_RST[14:0])
    else $error("fixed control bits changed");
  clk_dis_on_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ctrl_q[CTL_CLK_DIS] && s_pdn && !acc) |=> clk_disable)
    else $error("clocks not stopped in power-down");
  bad_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (access_s ##0 (pwrite && !mapped)) |=> $stable(ctrl_q))
    else $error("unmapped write changed control");

endmodule : plsr_top

/* include/plsr_pkg.sv */
// Package of offsets, field positions and reset values for the PHY status block
package plsr_pkg;
  // ----------------------------------------------------------------------
  // Register indices (word index; byte address is index times four)
  // ----------------------------------------------------------------------
  localparam logic [7:0]  IDX_BASIC_STATUS    = 8'h01;
  localparam logic [7:0]  IDX_AUTONEG_EXP     = 8'h06;
  localparam logic [7:0]  IDX_COMPOSITE_STAT  = 8'h10;
  localparam logic [7:0]  IDX_SPECIFIC_CTRL   = 8'h11;
  localparam logic [7:0]  IDX_INTR_SOURCE     = 8'h12;
  // ----------------------------------------------------------------------
  // Status and control field positions
  // ----------------------------------------------------------------------
  localparam int          STS_PAGE_RX         = 8;
  localparam int          STS_INTR            = 7;
  localparam int          STS_RFAULT          = 6;
  localparam int          STS_JABBER          = 5;
  localparam int          STS_ANEG_DONE       = 4;
  localparam int          STS_LOOPBACK        = 3;
  localparam int          STS_DUPLEX          = 2;
  localparam int          STS_SPEED10         = 1;
  localparam int          STS_LINK            = 0;
  localparam int          CTL_CLK_DIS         = 15;
  // ----------------------------------------------------------------------
  // Reset values and write mask
  // ----------------------------------------------------------------------
  localparam logic [15:0] SPECIFIC_CTRL_RST   = 16'h0108;
  localparam logic [15:0] CTRL_WR_MASK        = 16'h8000;
endpackage : plsr_pkg

/* sim/plsr_top_tb_top.sv */
// Self-checking bench for the PHY composite status and clock-disable block
`timescale 1ns/10ps
module plsr_top_tb_top;
  import plsr_pkg::*;
  logic        clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [9:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, clk_disable, er;
  logic        page_rx_evt = 0, intr_pending = 0, rfault_evt = 0, jabber_det = 0;
  logic        aneg_done = 0, loopback_en = 0, full_duplex = 0, speed_10 = 0;
  logic        link_up = 0, power_down = 0;
  int          err_count = 0, n_tests = 0;

  always #50 clk_sys = ~clk_sys;

  plsr_top uut (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .page_rx_evt  (page_rx_evt),
    .intr_pending (intr_pending),
    .rfault_evt   (rfault_evt),
    .jabber_det   (jabber_det),
    .aneg_done    (aneg_done),
    .loopback_en  (loopback_en),
    .full_duplex  (full_duplex),
    .speed_10     (speed_10),
    .link_up      (link_up),
    .power_down   (power_down),
    .clk_disable  (clk_disable)
  );

  // ----------------------------------------------------------------------
  // Reporting and bus helpers
  // ----------------------------------------------------------------------
  task end_sim;
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task chk32(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk32

  task chk1(input logic got, input logic exp, input string m);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask : chk1

  // One APB transfer; idle edge after it so psel is never re-driven in one step
  task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    chk1(pready, 1'b1, "pready");
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task rdc(input logic [7:0] idx, input logic [31:0] exp, input logic e, input string m);
    apb(1'b0, idx, 32'h0000_0000);
    chk32(rd, exp, m);
    chk1(er, e, m);
  endtask : rdc

  // Inputs cross a two-flop synchroniser, so allow a margin before reading
  task sync_wait;
    repeat (4) @(posedge clk_sys);
  endtask : sync_wait

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task stat(input logic [5:0] v, input logic [31:0] exp);
    {jabber_det, aneg_done, loopback_en, full_duplex, speed_10, link_up} <= v;
    sync_wait;
    rdc(IDX_COMPOSITE_STAT, exp, 1'b0, "status");
    rdc(IDX_COMPOSITE_STAT, exp, 1'b0, "status reread");
  endtask : stat

  task t_latch(input int k, input logic [7:0] cidx, input logic [31:0] b,
               input logic [31:0] crd);
    case (k)
      0: page_rx_evt <= 1'b1;
      1: intr_pending <= 1'b1;
      default: rfault_evt <= 1'b1;
    endcase
    repeat (3) @(posedge clk_sys);
    page_rx_evt  <= 1'b0;
    intr_pending <= 1'b0;
    rfault_evt   <= 1'b0;
    sync_wait;
    rdc(IDX_COMPOSITE_STAT, b, 1'b0, "latched");
    rdc(IDX_COMPOSITE_STAT, b, 1'b0, "latched kept");
    rdc(cidx, crd, 1'b0, "clearing read");
    rdc(IDX_COMPOSITE_STAT, 32'h0000_0000, 1'b0, "cleared");
  endtask : t_latch

  // The clock-disable bit stops the clocks while in power-down; power-down alone leaves them running
  task t_ctrl;
    power_down <= 1'b1;
    sync_wait;
    chk1(clk_disable, 1'b0, "power-down alone");
    apb(1'b1, IDX_SPECIFIC_CTRL, 32'hFFFF_FFFF);
    rdc(IDX_SPECIFIC_CTRL, 32'h0000_8108, 1'b0, "ctrl wr");
    sync_wait;
    chk1(clk_disable, 1'b1, "clocks off");
    apb(1'b1, IDX_SPECIFIC_CTRL, 32'h0000_0000);
    sync_wait;
    chk1(clk_disable, 1'b0, "clocks back");
    rdc(IDX_SPECIFIC_CTRL, {16'h0000, SPECIFIC_CTRL_RST}, 1'b0, "ctrl clr");
    power_down <= 1'b0;
  endtask : t_ctrl

  // Reset in mid-run drops a latched fault and restores the control word
  task t_reset;
    @(posedge clk_sys);
    power_down <= 1'b1;
    rfault_evt <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rfault_evt <= 1'b0;
    sync_wait;
    apb(1'b1, IDX_SPECIFIC_CTRL, 32'h0000_8000);
    rdc(IDX_COMPOSITE_STAT, 32'h0000_0040, 1'b0, "fault before reset");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk1(clk_disable, 1'b0, "clkdis after reset");
    rdc(IDX_COMPOSITE_STAT, 32'h0000_0000, 1'b0, "fault after reset");
    rdc(IDX_SPECIFIC_CTRL, {16'h0000, SPECIFIC_CTRL_RST}, 1'b0, "ctrl after reset");
    power_down <= 1'b0;
  endtask : t_reset

  task t_wr_ignore;
    apb(1'b1, IDX_COMPOSITE_STAT, 32'h0000_0000);
    chk1(er, 1'b0, "status wr err");
    rdc(IDX_COMPOSITE_STAT, 32'h0000_001D, 1'b0, "status wr");
  endtask : t_wr_ignore

  task t_unmapped;
    apb(1'b1, 8'hFF, 32'hFFFF_FFFF);
    chk1(er, 1'b1, "unmapped wr");
    rdc(IDX_SPECIFIC_CTRL, {16'h0000, SPECIFIC_CTRL_RST}, 1'b0, "ctrl kept");
    rdc(8'hFF, 32'h0000_0000, 1'b1, "unmapped rd");
  endtask : t_unmapped

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk1(clk_disable, 1'b0, "clkdis rst");
    rdc(IDX_SPECIFIC_CTRL, {16'h0000, SPECIFIC_CTRL_RST}, 1'b0, "ctrl rst");
    stat(6'h2A, 32'h0000_002A);
    stat(6'h15, 32'h0000_0015);
    stat(6'h3D, 32'h0000_001D);
    t_wr_ignore;
    stat(6'h00, 32'h0000_0000);
    t_latch(0, IDX_AUTONEG_EXP, 32'h0000_0100, 32'h0000_0002);
    t_latch(1, IDX_INTR_SOURCE, 32'h0000_0080, 32'h0000_0001);
    t_latch(2, IDX_BASIC_STATUS, 32'h0000_0040, 32'h0000_0000);
    t_ctrl;
    t_reset;
    t_unmapped;
    end_sim;
  end

  // Whole run needs well under 1000 cycles
  initial begin
    repeat (3000) @(posedge clk_sys);
    err_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_sim;
  end
endmodule : plsr_top_tb_top
